// File: cfg_access_pkg.sv
// Token codes, address patterns and carrier types for the config requester
package cfg_access_pkg;
  // Control token values
  localparam logic [7:0] TOK_END       = 8'h01;
  localparam logic [7:0] TOK_ACK       = 8'h03;
  localparam logic [7:0] TOK_NACK      = 8'h04;
  localparam logic [7:0] TOK_PERIPH_WR = 8'h24;
  localparam logic [7:0] TOK_PERIPH_RD = 8'h25;
  localparam logic [7:0] TOK_CFG_WR    = 8'hC0;
  localparam logic [7:0] TOK_CFG_RD    = 8'hC1;
  // Destination low halves, the peripheral low byte and the no-reply marker
  localparam logic [15:0] DEST_TILE_LO  = 16'hC20C;
  localparam logic [15:0] DEST_NODE_LO  = 16'hC30C;
  localparam logic [7:0]  DEST_PERIPH_LO = 8'h02;
  localparam logic [7:0]  NO_REPLY_LO   = 8'hFF;
  // Status resource type, the low byte of ps_resid_out
  localparam logic [7:0]  PS_RES_TYPE   = 8'h0B;
  // Message body: 9 bytes at most
  localparam int          MSG_BYTES     = 9;
  localparam logic [3:0]  CFG_WR_BYTES  = 4'h9;
  localparam logic [3:0]  CFG_RD_BYTES  = 4'h5;
  localparam logic [3:0]  PER_HDR_BYTES = 4'h5;
  localparam logic [2:0]  WORD_BYTES    = 3'h4;

  typedef enum logic [2:0] {
    K_TILE_WR, K_TILE_RD, K_NODE_WR, K_NODE_RD, K_PERIPH_WR, K_PERIPH_RD
  } req_kind_t;

  typedef struct packed {
    req_kind_t   kind;
    logic [15:0] tgt_id;     // Tile or node identifier
    logic [7:0]  periph_id;
    logic [23:0] ret_id;     // Return channel-end upper bits
    logic [15:0] reg_num;
    logic [7:0]  size;       // Peripheral byte count, 1..4
    logic [31:0] data;
  } req_cmd_t;

  typedef struct packed {
    logic       ctl;         // Control token when set
    logic [7:0] val;
  } link_tok_t;

  typedef struct packed {
    logic        ok;
    logic        no_reply;
    logic [31:0] data;
  } req_result_t;
endpackage

// File: cfg_requester.sv
// Host-side requester for token-framed configuration register access
`timescale 1ns/10ps

module resp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             sys_clk_in,
  input  wire logic             rst_b_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             push, pop;

  // Honest full and empty from the occupancy count
  assign in_ready_out  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_r != '0);
  assign out_data_out  = mem_r[rp_r];
  assign push = in_valid_in && in_ready_out;
  assign pop  = out_valid_out && out_ready_in;

  // Pointer and storage update
  always_comb begin
    mem_nxt = mem_r;
    wp_nxt  = wp_r;
    rp_nxt  = rp_r;
    if (push) begin
      mem_nxt[wp_r] = in_data_in;
      wp_nxt = (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
    end
    if (pop) begin
      rp_nxt = (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
    end
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < DEPTH; i++) mem_r[i] <= '0;
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      mem_r <= mem_nxt;
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule // resp_fifo

module cfg_requester
  import cfg_access_pkg::*;
#(
  parameter int RESULT_DEPTH = 2
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        cmd_valid_in,
  output logic             cmd_ready_out,
  input  wire req_cmd_t    cmd_in,
  output logic             tx_valid_out,
  input  wire logic        tx_ready_in,
  output link_tok_t        tx_tok_out,
  input  wire logic        rx_valid_in,
  output logic             rx_ready_out,
  input  wire link_tok_t   rx_tok_in,
  output logic [31:0]      dest_out,
  output logic [31:0]      ps_resid_out,
  output logic             res_valid_out,
  input  wire logic        res_ready_in,
  output req_result_t      res_out
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_HEAD, ST_BODY, ST_TAIL, ST_RHDR, ST_RDATA, ST_REND, ST_PUSH
  } seq_state_t;

  seq_state_t           st_r, st_nxt;
  req_kind_t            kind_r, kind_nxt;
  logic [8*MSG_BYTES-1:0] msg_r, msg_nxt;
  logic [3:0]           left_r, left_nxt;
  logic [2:0]           rxcnt_r, rxcnt_nxt;
  logic [31:0]          rdata_r, rdata_nxt;
  logic [7:0]           hdr_r, hdr_nxt;
  logic                 ok_r, ok_nxt, nrep_r, nrep_nxt;
  logic [31:0]          dest_nxt, resid_nxt;
  logic [2:0]           size_eff;
  logic [31:0]          data_l;
  logic                 is_wr, push_ready, fire;
  req_result_t          push_data;

  // Clamp peripheral size to one word; left-justify the data bytes
  always_comb begin
    size_eff = (cmd_in.size == 8'h00 || cmd_in.size > 8'h04) ? WORD_BYTES
                                                             : cmd_in.size[2:0];
    data_l   = cmd_in.data << (6'(WORD_BYTES - size_eff) * 6'd8);
    is_wr    = (cmd_in.kind == K_TILE_WR) || (cmd_in.kind == K_NODE_WR) ||
               (cmd_in.kind == K_PERIPH_WR);
  end

  assign cmd_ready_out = (st_r == ST_IDLE);
  assign fire          = cmd_valid_in && cmd_ready_out;
  assign tx_valid_out  = (st_r == ST_HEAD) || (st_r == ST_BODY) || (st_r == ST_TAIL);
  assign rx_ready_out  = (st_r == ST_RHDR) || (st_r == ST_RDATA) || (st_r == ST_REND);

  // Outgoing token: framing tokens around the MSB-first body
  always_comb begin
    tx_tok_out = '{ctl: 1'b1, val: TOK_END};
    if (st_r == ST_HEAD) tx_tok_out = '{ctl: 1'b1, val: hdr_r};
    else if (st_r == ST_BODY) tx_tok_out = '{ctl: 1'b0, val: msg_r[8*MSG_BYTES-1 -: 8]};
  end

  // Sequencer: load, send, collect reply, hand result over
  always_comb begin
    st_nxt    = st_r;
    kind_nxt  = kind_r;
    msg_nxt   = msg_r;
    left_nxt  = left_r;
    rxcnt_nxt = rxcnt_r;
    rdata_nxt = rdata_r;
    hdr_nxt   = hdr_r;
    ok_nxt    = ok_r;
    nrep_nxt  = nrep_r;
    dest_nxt  = dest_out;
    resid_nxt = ps_resid_out;
    case (st_r)
      ST_IDLE: begin
        if (fire) begin
          kind_nxt  = cmd_in.kind;
          rdata_nxt = '0;
          ok_nxt    = 1'b0;
          resid_nxt = {8'h00, cmd_in.reg_num, PS_RES_TYPE};
          nrep_nxt  = is_wr && (cmd_in.ret_id[7:0] == NO_REPLY_LO);
          case (cmd_in.kind)
            K_TILE_WR, K_NODE_WR: begin
              // config write layout, return id leads
              hdr_nxt   = TOK_CFG_WR;
              msg_nxt   = {cmd_in.ret_id, cmd_in.reg_num, cmd_in.data};
              left_nxt  = CFG_WR_BYTES;
              rxcnt_nxt = '0;
            end
            K_TILE_RD, K_NODE_RD: begin
              hdr_nxt   = TOK_CFG_RD;
              msg_nxt   = {cmd_in.ret_id, cmd_in.reg_num, 32'h0000_0000};
              left_nxt  = CFG_RD_BYTES;
              rxcnt_nxt = WORD_BYTES;
            end
            K_PERIPH_WR: begin
              hdr_nxt   = TOK_PERIPH_WR;
              msg_nxt   = {cmd_in.ret_id, cmd_in.reg_num[7:0], 5'h00, size_eff, data_l};
              left_nxt  = PER_HDR_BYTES + {1'b0, size_eff};
              rxcnt_nxt = '0;
            end
            default: begin
              hdr_nxt   = TOK_PERIPH_RD;
              msg_nxt   = {cmd_in.ret_id, cmd_in.reg_num[7:0], 5'h00, size_eff, 32'h0};
              left_nxt  = PER_HDR_BYTES;
              rxcnt_nxt = size_eff;
            end
          endcase
          if (cmd_in.kind == K_TILE_WR || cmd_in.kind == K_TILE_RD)
            dest_nxt = {cmd_in.tgt_id, DEST_TILE_LO};
          else if (cmd_in.kind == K_NODE_WR || cmd_in.kind == K_NODE_RD)
            dest_nxt = {cmd_in.tgt_id, DEST_NODE_LO};
          else
            dest_nxt = {cmd_in.tgt_id, cmd_in.periph_id, DEST_PERIPH_LO};
          st_nxt = ST_HEAD;
        end
      end
      ST_HEAD: if (tx_ready_in) st_nxt = ST_BODY;
      ST_BODY: begin
        if (tx_ready_in) begin
          // shift out most significant byte first
          msg_nxt  = {msg_r[8*MSG_BYTES-9:0], 8'h00};
          left_nxt = left_r - 4'h1;
          if (left_r == 4'h1) st_nxt = ST_TAIL;
        end
      end
      ST_TAIL: begin
        if (tx_ready_in) begin
          ok_nxt = nrep_r;
          st_nxt = nrep_r ? ST_PUSH : ST_RHDR;
        end
      end
      ST_RHDR: begin
        if (rx_valid_in) begin
          ok_nxt = rx_tok_in.ctl && (rx_tok_in.val == TOK_ACK);
          if (rx_tok_in.ctl && rx_tok_in.val == TOK_ACK)
            st_nxt = (rxcnt_r != '0) ? ST_RDATA : ST_REND;
          else if (rx_tok_in.ctl && rx_tok_in.val == TOK_END)
            st_nxt = ST_PUSH;
          else
            st_nxt = ST_REND;
        end
      end
      ST_RDATA: begin
        if (rx_valid_in) begin
          if (rx_tok_in.ctl) begin
            // Early control token means a malformed reply
            ok_nxt = 1'b0;
            st_nxt = (rx_tok_in.val == TOK_END) ? ST_PUSH : ST_REND;
          end else begin
            rdata_nxt = {rdata_r[23:0], rx_tok_in.val};
            rxcnt_nxt = rxcnt_r - 3'h1;
            if (rxcnt_r == 3'h1) st_nxt = ST_REND;
          end
        end
      end
      ST_REND: begin
        if (rx_valid_in && rx_tok_in.ctl && rx_tok_in.val == TOK_END) st_nxt = ST_PUSH;
      end
      ST_PUSH: if (push_ready) st_nxt = ST_IDLE;
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_r         <= ST_IDLE;
      kind_r       <= K_TILE_WR;
      msg_r        <= '0;
      left_r       <= '0;
      rxcnt_r      <= '0;
      rdata_r      <= '0;
      hdr_r        <= '0;
      ok_r         <= 1'b0;
      nrep_r       <= 1'b0;
      dest_out     <= '0;
      ps_resid_out <= '0;
    end else begin
      st_r         <= st_nxt;
      kind_r       <= kind_nxt;
      msg_r        <= msg_nxt;
      left_r       <= left_nxt;
      rxcnt_r      <= rxcnt_nxt;
      rdata_r      <= rdata_nxt;
      hdr_r        <= hdr_nxt;
      ok_r         <= ok_nxt;
      nrep_r       <= nrep_nxt;
      dest_out     <= dest_nxt;
      ps_resid_out <= resid_nxt;
    end
  end

  // Result buffer: a stalled consumer holds the sequencer in ST_PUSH
  assign push_data = '{ok: ok_r, no_reply: nrep_r, data: rdata_r};
  resp_fifo #(.WIDTH($bits(req_result_t)), .DEPTH(RESULT_DEPTH)) u_res_fifo (
    .sys_clk_in    (sys_clk_in),
    .rst_b_in      (rst_b_in),
    .in_valid_in   (st_r == ST_PUSH),
    .in_ready_out  (push_ready),
    .in_data_in    (push_data),
    .out_valid_out (res_valid_out),
    .out_ready_in  (res_ready_in),
    .out_data_out  (res_out)
  );

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);

  a_no_reply_skip: assert property ((st_r == ST_TAIL) && tx_ready_in && nrep_r |=> (st_r == ST_PUSH) && !rx_ready_out) else $error("no-reply write waited for reply");
  a_head_token: assert property ((st_r == ST_HEAD) |-> tx_tok_out.ctl && (tx_tok_out.val == hdr_r)) else $error("bad header token");
  a_tail_token: assert property ((st_r == ST_BODY) && tx_ready_in && (left_r == 4'h1) |=> tx_tok_out.ctl && (tx_tok_out.val == TOK_END)) else $error("missing end token");
  a_msb_first: assert property ((st_r == ST_BODY) && tx_ready_in && (left_r > 4'h1) |=> !tx_tok_out.ctl && (tx_tok_out.val == $past(msg_r[63:56]))) else $error("byte order broken");
  a_ret_lead: assert property (fire |=> ##1 (msg_r[71:48] == $past(cmd_in.ret_id, 2))) else $error("return id not leading");
  a_ps_resid: assert property (fire |=> ps_resid_out[23:0] == {$past(cmd_in.reg_num), 8'h0B}) else $error("status id wrong");
  a_dest_tile: assert property (fire && (cmd_in.kind == K_TILE_RD) |=> (dest_out[15:0] == 16'hC20C) && (hdr_r == 8'hC1)) else $error("tile read setup wrong");
  a_dest_node: assert property (fire && (cmd_in.kind == K_NODE_WR) |=> (dest_out[15:0] == 16'hC30C) && (left_r == 4'h9)) else $error("node write setup wrong");
  a_dest_periph: assert property (fire && (cmd_in.kind == K_PERIPH_RD) |=> (dest_out[7:0] == 8'h02) && (hdr_r == 8'h25)) else $error("periph read setup wrong");
  a_read_data: assert property ((st_r == ST_RDATA) && rx_valid_in && !rx_tok_in.ctl |=> rdata_r[7:0] == $past(rx_tok_in.val)) else $error("read byte lost");

  c_cfg_write: cover property (fire && (cmd_in.kind == K_NODE_WR) ##[1:40] (st_r == ST_PUSH) && ok_r);
  c_cfg_read: cover property ((st_r == ST_RDATA) ##[1:20] (st_r == ST_PUSH) && ok_r);
  c_fail: cover property ((st_r == ST_RHDR) && rx_valid_in && rx_tok_in.val == TOK_NACK);
  c_stall: cover property ((st_r == ST_PUSH) && !push_ready);
endmodule // cfg_requester

// File: cfg_target_model.sv
// Behavioural register target answering framed config requests
`timescale 1ns/10ps
module cfg_target_model
  import cfg_access_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        tx_valid_in,
  output logic             tx_ready_out,
  input  wire link_tok_t   tx_tok_in,
  output logic             rx_valid_out,
  input  wire logic        rx_ready_in,
  output link_tok_t        rx_tok_out,
  input  wire logic        fail_in,
  input  wire logic        slow_in,
  input  wire logic [31:0] rd_data_in
);
  link_tok_t   msg[$];
  link_tok_t   rq[$];
  logic        tick_r;
  logic        wr;
  logic [7:0]  hd;
  int          n;
  // Slow mode accepts and offers only every other cycle
  assign tx_ready_out = !slow_in || tick_r;
  // Collect one message, then queue its reply
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      msg.delete();
      rq.delete();
      tick_r       <= 1'b0;
      rx_valid_out <= 1'b0;
      rx_tok_out   <= '0;
    end else begin
      tick_r <= ~tick_r;
      if (rx_valid_out && rx_ready_in) begin
        rq.pop_front();
      end
      if (tx_valid_in && tx_ready_out) begin
        msg.push_back(tx_tok_in);
        if (tx_tok_in.ctl && tx_tok_in.val == TOK_END) begin
          hd = msg[0].val;
          wr = (hd == TOK_CFG_WR) || (hd == TOK_PERIPH_WR);
          if (!(wr && msg[3].val == NO_REPLY_LO)) begin
            rq.push_back({1'b1, fail_in ? TOK_NACK : TOK_ACK});
            n = (hd == TOK_CFG_RD) ? 4 : (hd == TOK_PERIPH_RD) ? int'(msg[5].val) : 0;
            if (fail_in) begin
              n = 0;
            end
            for (int i = n - 1; i >= 0; i--) begin
              rq.push_back({1'b0, rd_data_in[8*i +: 8]});
            end
            rq.push_back({1'b1, TOK_END});
          end
          msg.delete();
        end
      end
      // Hold an offered token until taken; idle line shows junk
      if (!(rx_valid_out && !rx_ready_in)) begin
        rx_valid_out <= (rq.size() != 0) && tx_ready_out;
        rx_tok_out   <= (rq.size() != 0 && tx_ready_out) ? rq[0] : link_tok_t'(~rx_tok_out);
      end
    end
  end
endmodule // cfg_target_model

// File: cfg_requester_tb.sv
// Self-checking bench for the config requester
`timescale 1ns/10ps
module cfg_requester_tb;
  import cfg_access_pkg::*;
  localparam logic [15:0] TGT = 16'h1A2B;
  localparam logic [7:0]  PER = 8'h5C;
  logic        sys_clk_in, rst_b_in, cmd_valid, cmd_ready, tx_valid, tx_ready;
  logic        rx_valid, rx_ready, res_valid, res_ready, fail, slow;
  logic [31:0] dest, resid, rd_data;
  req_cmd_t    cmd;
  link_tok_t   tx_tok, rx_tok;
  req_result_t res;
  link_tok_t   txq[$], expq[$];
  int          err_count, num_checks, rxn;

  cfg_requester #(.RESULT_DEPTH(2)) u_cfg_requester (.sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in), .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready), .cmd_in(cmd),
    .tx_valid_out(tx_valid), .tx_ready_in(tx_ready), .tx_tok_out(tx_tok),
    .rx_valid_in(rx_valid), .rx_ready_out(rx_ready), .rx_tok_in(rx_tok), .dest_out(dest),
    .ps_resid_out(resid), .res_valid_out(res_valid), .res_ready_in(res_ready), .res_out(res));
  cfg_target_model u_cfg_target_model (.clk_in(sys_clk_in), .rst_b_in(rst_b_in),
    .tx_valid_in(tx_valid), .tx_ready_out(tx_ready), .tx_tok_in(tx_tok),
    .rx_valid_out(rx_valid), .rx_ready_in(rx_ready), .rx_tok_out(rx_tok),
    .fail_in(fail), .slow_in(slow), .rd_data_in(rd_data));

  initial begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end
  // Record every outgoing token and count the incoming ones
  always @(posedge sys_clk_in) begin
    if (tx_valid && tx_ready) txq.push_back(tx_tok);
    if (rx_valid && rx_ready) rxn++;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tok(input logic c, input logic [7:0] v);
    expq.push_back({c, v});
  endtask
  // Offer one command, then predict its message and destination
  task automatic issue(input req_kind_t k, input logic [23:0] ret, input logic [15:0] rg,
                       input logic [7:0] sz, input logic [31:0] d);
    int i, n;
    logic per, wr;
    i = 0;
    per = (k == K_PERIPH_WR) || (k == K_PERIPH_RD);
    wr = (k == K_PERIPH_WR) || (k == K_TILE_WR) || (k == K_NODE_WR);
    @(negedge sys_clk_in);
    cmd <= '{k, TGT, PER, ret, rg, sz, d};
    cmd_valid <= 1'b1;
    while (cmd_ready !== 1'b1 && i < 400) begin
      @(negedge sys_clk_in);
      i++;
    end
    // A command never taken counts as a mismatch
    if (i >= 400) err_count++;
    @(negedge sys_clk_in);
    cmd_valid <= 1'b0;
    tok(1'b1, per ? (wr ? TOK_PERIPH_WR : TOK_PERIPH_RD) : (wr ? TOK_CFG_WR : TOK_CFG_RD));
    for (i = 2; i >= 0; i--) tok(1'b0, ret[8*i +: 8]);
    if (per) begin
      tok(1'b0, rg[7:0]);
      tok(1'b0, sz);
      n = wr ? int'(sz) : 0;
    end else begin
      tok(1'b0, rg[15:8]);
      tok(1'b0, rg[7:0]);
      n = wr ? 4 : 0;
    end
    for (i = n - 1; i >= 0; i--) tok(1'b0, d[8*i +: 8]);
    tok(1'b1, TOK_END);
    check(dest, per ? {TGT, PER, DEST_PERIPH_LO} : (k == K_TILE_WR || k == K_TILE_RD) ?
          {TGT, DEST_TILE_LO} : {TGT, DEST_NODE_LO});
    check(resid, {8'h00, rg, PS_RES_TYPE});
  endtask
  // Wait for a result, judge it and pop it
  task automatic pop(input logic ok, input logic nr, input logic rd, input logic [31:0] d);
    int i;
    i = 0;
    @(negedge sys_clk_in);
    while (res_valid !== 1'b1 && i < 400) begin
      @(negedge sys_clk_in);
      i++;
    end
    // A result that never shows counts as a mismatch
    if (i >= 400) err_count++;
    check({res.ok, res.no_reply}, {ok, nr});
    if (rd) check(res.data, d);
    res_ready <= 1'b1;
    @(negedge sys_clk_in);
    res_ready <= 1'b0;
  endtask
  task automatic msgs();
    check(txq.size(), expq.size());
    foreach (expq[i]) if (i < txq.size()) check(txq[i], expq[i]);
    txq.delete();
    expq.delete();
  endtask
  task automatic t_cfg();
    issue(K_NODE_WR, 24'h123456, 16'hA55A, 8'h00, 32'hDEADBEEF);
    pop(1'b1, 1'b0, 1'b0, 32'h0);
    fail = 1'b1;
    issue(K_TILE_WR, 24'h654321, 16'h0001, 8'h00, 32'h01020304);
    pop(1'b0, 1'b0, 1'b0, 32'h0);
    issue(K_NODE_RD, 24'h00AB01, 16'hFFFF, 8'h00, 32'h0);
    pop(1'b0, 1'b0, 1'b0, 32'h0);
    fail = 1'b0;
    issue(K_TILE_RD, 24'h0A0B0C, 16'h8001, 8'h00, 32'h0);
    pop(1'b1, 1'b0, 1'b1, rd_data);
    issue(K_NODE_RD, 24'h0A0B0D, 16'h0100, 8'h00, 32'h0);
    pop(1'b1, 1'b0, 1'b1, rd_data);
    msgs();
    $display("t_cfg done");
  endtask
  task automatic t_noreply();
    int n0;
    n0 = rxn;
    issue(K_NODE_WR, 24'h0012FF, 16'h0010, 8'h00, 32'hCAFE0001);
    pop(1'b1, 1'b1, 1'b0, 32'h0);
    issue(K_PERIPH_WR, 24'h0034FF, 16'h0022, 8'h01, 32'h000000A5);
    pop(1'b1, 1'b1, 1'b0, 32'h0);
    check(rxn - n0, 0);
    msgs();
    $display("t_noreply done");
  endtask
  task automatic t_periph();
    slow = 1'b1;
    for (int s = 1; s <= 4; s++) begin
      issue(K_PERIPH_WR, 24'h00C001, 16'h0033, 8'(s), 32'h11223344);
      pop(1'b1, 1'b0, 1'b0, 32'h0);
      issue(K_PERIPH_RD, 24'h00C002, 16'h0044, 8'(s), 32'h0);
      pop(1'b1, 1'b0, 1'b1, (s == 4) ? rd_data : rd_data & ((32'h1 << (8 * s)) - 32'h1));
    end
    slow = 1'b0;
    msgs();
    $display("t_periph done");
  endtask
  // Results pile up unpopped until the sequencer stalls
  task automatic t_buffer();
    for (int j = 0; j < 3; j++) issue(K_NODE_WR, 24'h000200, 16'(j), 8'h00, 32'h5A5A0000);
    repeat (30) @(negedge sys_clk_in);
    check(cmd_ready, 1'b0);
    for (int j = 0; j < 3; j++) pop(1'b1, 1'b0, 1'b0, 32'h0);
    msgs();
    $display("t_buffer done");
  endtask
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Cut a hang short well past the expected run
  initial begin
    #300000;
    err_count++;
    close_out();
  end
  initial begin
    {rst_b_in, cmd_valid, res_ready, fail, slow} = '0;
    cmd = '0;
    rd_data = 32'h89ABCDEF;
    repeat (6) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    rst_b_in = 1'b1;
    t_cfg();
    t_noreply();
    t_periph();
    t_buffer();
    close_out();
  end
endmodule // cfg_requester_tb
